// >>> bspd_cfg.svh
// Constants of the bipolar stepper phase decoder: offsets, fields, resets, timing
// What this block does
// [RULE1] see: level selects decode to 100, 71, 38 percent
// [RULE2] see: both selects low float both outputs
// [RULE3] see: direction high drives plus, low drives minus
// [RULE4] see: sequencer full step cycles four direction states
// [RULE5] see: sequencer half step inserts zero-current states
// [RULE6] see: sequencer quarter step walks sixteen magnitude states
// [RULE7] see: sequencer holds level selects low at power-up
// [RULE8] see: sleep stops oscillator and all output drivers
// [RULE9] see: sleep initialises everything including latched faults; code clears latches and drivers, not CTRL, MASK, STATUS
// [RULE10] see: thermal trip turns off and latches both channels
// [RULE11] see: thermal latch clears only by reboot or sleep
// [RULE12] see: outputs off until both supply monitors good
// [RULE13] see: per-channel overcurrent trip latches that channel off
// [RULE14] see: overcurrent latch clears only by reboot or sleep
// [RULE15] see: chop period comes from external RC oscillator
// [RULE16] see: bridge on each period until sense reached
`ifndef BSPD_CFG_SVH
`define BSPD_CFG_SVH

// ============================================================
// Timing
`define BSPD_CLK_PERIOD_NS 10
`define BSPD_BLANK_NS 250
`define BSPD_BLANK_CYC ((`BSPD_BLANK_NS + `BSPD_CLK_PERIOD_NS - 1) / `BSPD_CLK_PERIOD_NS)

// ============================================================
// Register byte offsets
`define BSPD_REG_CTRL 4'h0
`define BSPD_REG_STATUS 4'h4
`define BSPD_REG_MASK 4'h8
`define BSPD_REG_STATE 4'hC

// ============================================================
// Event bits of STATUS and MASK
`define BSPD_EV_W 4
`define BSPD_EV_TSD 0
`define BSPD_EV_OCP_A 1
`define BSPD_EV_OCP_B 2
`define BSPD_EV_PWR 3

// ============================================================
// Reset values
`define BSPD_CTRL_RST 8'(`BSPD_BLANK_CYC)
`define BSPD_MASK_RST 4'h0

`endif

// >>> bspd_pkg.sv
// Types shared by the bipolar stepper phase decoder
package bspd_pkg;

    // Coil-current magnitude, code equals the two level-select bits
    typedef enum logic [1:0] {
        MAG_0 = 2'h0,
        MAG_38 = 2'h1,
        MAG_71 = 2'h2,
        MAG_100 = 2'h3
    } bspd_mag_t;

    // Chopper states, one-hot
    typedef enum logic [3:0] {
        CH_IDLE = 4'h1,
        CH_BLANK = 4'h2,
        CH_DRIVE = 4'h4,
        CH_DECAY = 4'h8
    } bspd_chop_state_t;

endpackage

// >>> bspd_chop_ch.sv
// Constant-current chopper of one bridge channel
`timescale 1ns/100ps
`default_nettype none
module bspd_chop_ch (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic chan_en,
    input wire logic period_start,
    input wire logic sense,
    input wire logic [7:0] blank_cyc,
    output logic bridge_on
);

    bspd_pkg::bspd_chop_state_t state_r;
    bspd_pkg::bspd_chop_state_t state_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;

    // ============================================================
    // Next state: blank the sense after turn-on, since switching spikes fake a trip
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            bspd_pkg::CH_IDLE:
            begin
                if (period_start) // see [RULE15]
                begin
                    state_nxt = bspd_pkg::CH_BLANK;
                    cnt_nxt = 8'h00;
                end
            end
            bspd_pkg::CH_BLANK:
            begin
                if (period_start)
                    cnt_nxt = 8'h00;
                else if (cnt_r >= blank_cyc)
                    state_nxt = bspd_pkg::CH_DRIVE;
                else
                    cnt_nxt = cnt_r + 8'h01;
            end
            bspd_pkg::CH_DRIVE:
            begin
                if (period_start)
                begin
                    state_nxt = bspd_pkg::CH_BLANK;
                    cnt_nxt = 8'h00;
                end
                else if (sense)
                    state_nxt = bspd_pkg::CH_DECAY; // see [RULE16]
            end
            bspd_pkg::CH_DECAY:
            begin
                if (period_start) // see [RULE16]
                begin
                    state_nxt = bspd_pkg::CH_BLANK;
                    cnt_nxt = 8'h00;
                end
            end
            default:
            begin
                state_nxt = bspd_pkg::CH_IDLE;
                cnt_nxt = 8'h00;
            end
        endcase
        if (!chan_en)
            state_nxt = bspd_pkg::CH_IDLE;
    end

    // State registers
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= bspd_pkg::CH_IDLE;
            cnt_r <= 8'h00;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign bridge_on = (state_r == bspd_pkg::CH_BLANK) || (state_r == bspd_pkg::CH_DRIVE);

    // ============================================================
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_drive_hit;
        clk_en && chan_en && (state_r == bspd_pkg::CH_DRIVE) && sense && !period_start;
    endsequence

    AST_CHOP_OFF: assert property (s_drive_hit |=> !bridge_on ##0 (state_r == bspd_pkg::CH_DECAY)) // see [RULE16]
        else $error("bridge stayed on after sense reached target");

    AST_CHOP_START: assert property (clk_en && chan_en && period_start |=> bridge_on) // see [RULE15]
        else $error("bridge not turned on at chop period start");

endmodule
`default_nettype wire

// >>> bspd_top.sv
// Phase decoder, fault latches, chopping control and Avalon-MM registers
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "bspd_cfg.svh"
module bspd_top (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic lvl_sel_a_hi,
    input wire logic lvl_sel_a_lo,
    input wire logic lvl_sel_b_hi,
    input wire logic lvl_sel_b_lo,
    input wire logic dir_a,
    input wire logic dir_b,
    input wire logic awake,
    input wire logic thermal_trip,
    input wire logic overcurrent_trip_a,
    input wire logic overcurrent_trip_b,
    input wire logic motor_supply_ok,
    input wire logic vcc_ok,
    input wire logic chop_osc_set,
    input wire logic sense_ch_a,
    input wire logic sense_ch_b,
    output logic out_a_pos_o,
    output logic out_a_pos_oe,
    output logic out_a_neg_o,
    output logic out_a_neg_oe,
    output logic out_b_pos_o,
    output logic out_b_pos_oe,
    output logic out_b_neg_o,
    output logic out_b_neg_oe,
    output logic [1:0] mag_a,
    output logic [1:0] mag_b,
    output logic osc_run,
    output logic low_power,
    output logic irq,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // Positions in the synchroniser vector
    localparam int I_AHI = 0;
    localparam int I_ALO = 1;
    localparam int I_BHI = 2;
    localparam int I_BLO = 3;
    localparam int I_DIRA = 4;
    localparam int I_DIRB = 5;
    localparam int I_AWAKE = 6;
    localparam int I_TSD = 7;
    localparam int I_OCA = 8;
    localparam int I_OCB = 9;
    localparam int I_VM = 10;
    localparam int I_VCC = 11;
    localparam int I_OSC = 12;
    localparam int I_SNA = 13;
    localparam int I_SNB = 14;
    localparam int NPIN = 15;

    // Level selects map straight onto the magnitude code
    function automatic bspd_pkg::bspd_mag_t bspd_mag_decode(input logic hi, input logic lo);
        bspd_mag_decode = bspd_pkg::bspd_mag_t'({hi, lo}); // see [RULE1]
    endfunction

    // Aligned word hit for the register decode
    function automatic logic bspd_word_hit(input logic [3:0] addr, input logic [3:0] offs);
        bspd_word_hit = (addr == offs);
    endfunction

    // ============================================================
    // Pin synchronisers
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_r;
    logic [NPIN-1:0] sync2_r;

    assign pin_raw = {sense_ch_b, sense_ch_a, chop_osc_set, vcc_ok, motor_supply_ok,
                      overcurrent_trip_b, overcurrent_trip_a, thermal_trip, awake,
                      dir_b, dir_a, lvl_sel_b_lo, lvl_sel_b_hi, lvl_sel_a_lo, lvl_sel_a_hi};

    // Every pin is asynchronous to sys_clk, two stages each
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else if (clk_en)
        begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    logic [1:0] hi_s;
    logic [1:0] lo_s;
    logic [1:0] dir_s;
    logic [1:0] ocp_s;
    logic [1:0] sense_s;
    logic awake_s;
    logic thermal_s;
    logic pwr_ok_s;
    logic osc_s;

    assign hi_s = {sync2_r[I_BHI], sync2_r[I_AHI]};
    assign lo_s = {sync2_r[I_BLO], sync2_r[I_ALO]};
    assign dir_s = {sync2_r[I_DIRB], sync2_r[I_DIRA]};
    assign ocp_s = {sync2_r[I_OCB], sync2_r[I_OCA]};
    assign sense_s = {sync2_r[I_SNB], sync2_r[I_SNA]};
    assign awake_s = sync2_r[I_AWAKE];
    assign thermal_s = sync2_r[I_TSD];
    assign pwr_ok_s = sync2_r[I_VM] & sync2_r[I_VCC];
    assign osc_s = sync2_r[I_OSC];

    // ============================================================
    // Core state: fault latches, decode and bridge drive
    logic tsd_r;
    logic tsd_nxt;
    logic [1:0] ocp_r;
    logic [1:0] ocp_nxt;
    logic pwr_d_r;
    logic osc_d_r;
    logic osc_run_r;
    logic osc_run_nxt;
    bspd_pkg::bspd_mag_t mag_r [2];
    bspd_pkg::bspd_mag_t mag_nxt [2];
    logic [1:0] oe_r;
    logic [1:0] oe_nxt;
    logic [1:0] pos_r;
    logic [1:0] pos_nxt;
    logic [1:0] neg_r;
    logic [1:0] neg_nxt;
    logic [1:0] chan_en;
    logic [1:0] bridge_on;
    logic period_start;
    logic [7:0] blank_r;

    // Sleep resets the latches each cycle it is low, so leaving them needs high-low-high
    always_comb
    begin
        tsd_nxt = awake_s & (tsd_r | thermal_s); // see [RULE9] see [RULE10] see [RULE11]
        osc_run_nxt = awake_s; // see [RULE8]
        for (int c = 0; c < 2; c++)
        begin
            mag_nxt[c] = bspd_mag_decode(hi_s[c], lo_s[c]); // see [RULE1]
            ocp_nxt[c] = awake_s & (ocp_r[c] | ocp_s[c]); // see [RULE13] see [RULE14]
            // Zero magnitude floats the bridge whatever the direction says
            chan_en[c] = awake_s & pwr_ok_s & ~tsd_r & ~ocp_r[c] // see [RULE8] see [RULE12]
                         & (mag_nxt[c] != bspd_pkg::MAG_0); // see [RULE2]
            oe_nxt[c] = chan_en[c] & bridge_on[c]; // see [RULE16]
            pos_nxt[c] = oe_nxt[c] & dir_s[c]; // see [RULE3]
            neg_nxt[c] = oe_nxt[c] & ~dir_s[c]; // see [RULE3]
        end
    end

    // Oscillator edge starts a chop period, only while awake
    assign period_start = awake_s & osc_s & ~osc_d_r; // see [RULE8] see [RULE15]

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tsd_r <= 1'b0;
            ocp_r <= 2'h0;
            pwr_d_r <= 1'b0;
            osc_d_r <= 1'b0;
            osc_run_r <= 1'b0;
            mag_r[0] <= bspd_pkg::MAG_0;
            mag_r[1] <= bspd_pkg::MAG_0;
            oe_r <= 2'h0;
            pos_r <= 2'h0;
            neg_r <= 2'h0;
        end
        else if (clk_en)
        begin
            tsd_r <= tsd_nxt;
            ocp_r <= ocp_nxt;
            pwr_d_r <= pwr_ok_s;
            osc_d_r <= osc_s;
            osc_run_r <= osc_run_nxt;
            mag_r[0] <= mag_nxt[0];
            mag_r[1] <= mag_nxt[1];
            oe_r <= oe_nxt;
            pos_r <= pos_nxt;
            neg_r <= neg_nxt;
        end
    end

    // One chopper per channel
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_chop
            bspd_chop_ch u_chop (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .clk_en(clk_en),
                .chan_en(chan_en[g]),
                .period_start(period_start),
                .sense(sense_s[g]),
                .blank_cyc(blank_r),
                .bridge_on(bridge_on[g])
            );
        end
    endgenerate

    assign out_a_pos_o = pos_r[0];
    assign out_a_neg_o = neg_r[0];
    assign out_a_pos_oe = oe_r[0];
    assign out_a_neg_oe = oe_r[0];
    assign out_b_pos_o = pos_r[1];
    assign out_b_neg_o = neg_r[1];
    assign out_b_pos_oe = oe_r[1];
    assign out_b_neg_oe = oe_r[1];
    assign mag_a = mag_r[0];
    assign mag_b = mag_r[1];
    assign osc_run = osc_run_r;
    assign low_power = ~osc_run_r;

    // ============================================================
    // Avalon-MM slave, events and interrupt
    logic ack_r;
    logic ack_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [31:0] rmux;
    logic [7:0] blank_nxt;
    logic [`BSPD_EV_W-1:0] mask_r;
    logic [`BSPD_EV_W-1:0] mask_nxt;
    logic [`BSPD_EV_W-1:0] status_r;
    logic [`BSPD_EV_W-1:0] status_nxt;
    logic [`BSPD_EV_W-1:0] ev;
    logic [`BSPD_EV_W-1:0] clr;
    logic irq_r;
    logic irq_nxt;
    logic wr_go;

    // One wait cycle per access; read data are captured while waitrequest is high
    always_comb
    begin
        ack_nxt = (avs_read | avs_write) & ~ack_r;
        rmux = 32'h0;
        if (bspd_word_hit(avs_address, `BSPD_REG_CTRL))
            rmux[7:0] = blank_r;
        if (bspd_word_hit(avs_address, `BSPD_REG_STATUS))
            rmux[`BSPD_EV_W-1:0] = status_r;
        if (bspd_word_hit(avs_address, `BSPD_REG_MASK))
            rmux[`BSPD_EV_W-1:0] = mask_r;
        if (bspd_word_hit(avs_address, `BSPD_REG_STATE))
            rmux[12:0] = {oe_r, dir_s[1], mag_r[1], dir_s[0], mag_r[0],
                          awake_s, pwr_ok_s, ocp_r, tsd_r};
        rdata_nxt = (avs_read & ~ack_r) ? rmux : rdata_r;
        wr_go = avs_write & ack_r & avs_byteenable[0];
        blank_nxt = blank_r;
        mask_nxt = mask_r;
        if (wr_go && bspd_word_hit(avs_address, `BSPD_REG_CTRL))
            blank_nxt = avs_writedata[7:0];
        if (wr_go && bspd_word_hit(avs_address, `BSPD_REG_MASK))
            mask_nxt = avs_writedata[`BSPD_EV_W-1:0];
        ev = '0;
        ev[`BSPD_EV_TSD] = tsd_nxt & ~tsd_r;
        ev[`BSPD_EV_OCP_A] = ocp_nxt[0] & ~ocp_r[0];
        ev[`BSPD_EV_OCP_B] = ocp_nxt[1] & ~ocp_r[1];
        ev[`BSPD_EV_PWR] = pwr_ok_s & ~pwr_d_r;
        // Clear only what the read reported, so a later event is never lost
        clr = (avs_read && ack_r && bspd_word_hit(avs_address, `BSPD_REG_STATUS))
              ? rdata_r[`BSPD_EV_W-1:0] : '0;
        status_nxt = (status_r & ~clr) | ev;
        irq_nxt = |(status_nxt & mask_nxt);
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0;
            blank_r <= `BSPD_CTRL_RST;
            mask_r <= `BSPD_MASK_RST;
            status_r <= '0;
            irq_r <= 1'b0;
        end
        else if (clk_en)
        begin
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
            blank_r <= blank_nxt;
            mask_r <= mask_nxt;
            status_r <= status_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign avs_readdata = rdata_r;
    assign irq = irq_r;

    // ============================================================
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_sleep_wake;
        (clk_en && !awake_s) ##1 (clk_en && awake_s);
    endsequence

    AST_MAG_71: assert property (clk_en && hi_s[0] && !lo_s[0] |=> mag_a == bspd_pkg::MAG_71) // see [RULE1]
        else $error("channel A level selects not decoded to 71 percent");

    AST_ZERO_HIZ: assert property (clk_en && !hi_s[1] && !lo_s[1] |=> !out_b_pos_oe && !out_b_neg_oe) // see [RULE2]
        else $error("channel B driven with zero magnitude");

    AST_DIR_POS: assert property (clk_en && chan_en[0] && bridge_on[0] && dir_s[0]
        |=> out_a_pos_oe && out_a_pos_o && !out_a_neg_o) // see [RULE3]
        else $error("channel A direction high did not drive plus output");

    AST_SLEEP_OFF: assert property (clk_en && !awake_s |=> !osc_run && low_power && oe_r == 2'h0) // see [RULE8]
        else $error("oscillator or drivers active during sleep");

    AST_SLEEP_INIT: assert property (clk_en && !awake_s |=> !tsd_r && ocp_r == 2'h0) // see [RULE9]
        else $error("sleep did not clear fault latches");

    AST_TSD_OFF: assert property (tsd_r && $past(tsd_r) && $past(clk_en) |-> oe_r == 2'h0) // see [RULE10]
        else $error("outputs on during thermal shutdown");

    AST_TSD_HOLD: assert property (clk_en && awake_s && tsd_r |=> tsd_r) // see [RULE11]
        else $error("thermal latch released while awake");

    AST_REARM: assert property (s_sleep_wake |-> !tsd_r && ocp_r == 2'h0) // see [RULE11] see [RULE14]
        else $error("faults still latched after sleep cycle");

    AST_POR: assert property ($past(clk_en) && $past(!pwr_ok_s) |-> oe_r == 2'h0) // see [RULE12]
        else $error("outputs on before supplies good");

    AST_OCP_OFF: assert property (ocp_r[1] && $past(ocp_r[1]) && $past(clk_en) |-> !out_b_pos_oe) // see [RULE13]
        else $error("channel B on during overcurrent latch");

    AST_OCP_HOLD: assert property (clk_en && awake_s && ocp_r[0] |=> ocp_r[0]) // see [RULE14]
        else $error("overcurrent latch released while awake");

endmodule
`default_nettype wire

// >>> bspd_seq_model.sv
// Far-side model: step sequencer, RC chopping oscillator and current comparators
`timescale 1ns/100ps
`default_nettype none
module bspd_seq_model #(
    parameter int OSC_HALF = 200,
    parameter int SENSE_CYC = 40
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [1:0] mode,
    input wire logic step,
    input wire logic sense_en,
    input wire logic osc_run,
    input wire logic oe_a,
    input wire logic oe_b,
    output logic lvl_sel_a_hi,
    output logic lvl_sel_a_lo,
    output logic lvl_sel_b_hi,
    output logic lvl_sel_b_lo,
    output logic dir_a,
    output logic dir_b,
    output logic chop_osc_set,
    output logic sense_ch_a,
    output logic sense_ch_b
);
    // ============================================================
    // Step tables, each entry {dir A, hi A, lo A, dir B, hi B, lo B}
    localparam logic [5:0] FULL [4] = '{6'h3F, 6'h1F, 6'h1B, 6'h3B};
    localparam logic [5:0] HALF [8] = '{6'h3F, 6'h07, 6'h1F, 6'h18,
        6'h1B, 6'h03, 6'h3B, 6'h38};
    localparam logic [5:0] QTR [16] = '{6'h36, 6'h2F, 6'h07, 6'h0F, 6'h16, 6'h1D,
        6'h18, 6'h19, 6'h12, 6'h0B, 6'h03, 6'h2B, 6'h32, 6'h39, 6'h38, 6'h3D};
    logic [3:0] idx_r;
    logic [5:0] st;
    int osc_cnt_r;
    int sen_a_r;
    int sen_b_r;

    // Table lookup; selects stay low until the sequencer is told to run
    always_comb
    begin
        case (mode)
            2'h0: st = FULL[idx_r[1:0]];
            2'h1: st = HALF[idx_r[2:0]];
            default: st = QTR[idx_r];
        endcase
        if (!run)
        begin
            st = 6'h00;
        end
    end
    assign {dir_a, lvl_sel_a_hi, lvl_sel_a_lo, dir_b, lvl_sel_b_hi, lvl_sel_b_lo} = st;
    // Comparator trips only after the bridge has pushed current for a while
    assign sense_ch_a = sense_en && (sen_a_r >= SENSE_CYC);
    assign sense_ch_b = sense_en && (sen_b_r >= SENSE_CYC);

    // Index, RC oscillator (stalls when the device disables it) and coil ramps
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            idx_r <= 4'h0;
            osc_cnt_r <= 0;
            chop_osc_set <= 1'b0;
            sen_a_r <= 0;
            sen_b_r <= 0;
        end
        else
        begin
            idx_r <= idx_r + 4'(step);
            if (osc_run)
            begin
                osc_cnt_r <= (osc_cnt_r == OSC_HALF - 1) ? 0 : osc_cnt_r + 1;
                chop_osc_set <= chop_osc_set ^ (osc_cnt_r == OSC_HALF - 1);
            end
            sen_a_r <= oe_a ? sen_a_r + 1 : 0;
            sen_b_r <= oe_b ? sen_b_r + 1 : 0;
        end
    end
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench of the stepper phase decoder
`timescale 1ns/100ps
`default_nettype none
`include "bspd_cfg.svh"
module testbench;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic awake = 1'b0;
    logic thermal_trip = 1'b0;
    logic oc_a = 1'b0;
    logic oc_b = 1'b0;
    logic motor_supply_ok = 1'b0, vcc_ok = 1'b1;
    logic run = 1'b0;
    logic [1:0] mode = 2'h0;
    logic step = 1'b0;
    logic sense_en = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic a_hi, a_lo, b_hi, b_lo, d_a, d_b, osc, s_a, s_b;
    logic ap_o, ap_oe, an_o, an_oe, bp_o, bp_oe, bn_o, bn_oe;
    logic [1:0] mag_a, mag_b;
    logic osc_run, low_power, irq;
    logic [3:0] oes;
    logic [31:0] q;
    int n_fail = 0;
    int num_checks = 0;

    assign oes = {ap_oe, an_oe, bp_oe, bn_oe};
    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    bspd_top u_bspd_top (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1),
        .lvl_sel_a_hi(a_hi), .lvl_sel_a_lo(a_lo), .lvl_sel_b_hi(b_hi), .lvl_sel_b_lo(b_lo),
        .dir_a(d_a), .dir_b(d_b), .awake(awake), .thermal_trip(thermal_trip),
        .overcurrent_trip_a(oc_a), .overcurrent_trip_b(oc_b),
        .motor_supply_ok(motor_supply_ok), .vcc_ok(vcc_ok), .chop_osc_set(osc),
        .sense_ch_a(s_a), .sense_ch_b(s_b), .out_a_pos_o(ap_o), .out_a_pos_oe(ap_oe),
        .out_a_neg_o(an_o), .out_a_neg_oe(an_oe), .out_b_pos_o(bp_o), .out_b_pos_oe(bp_oe),
        .out_b_neg_o(bn_o), .out_b_neg_oe(bn_oe), .mag_a(mag_a), .mag_b(mag_b),
        .osc_run(osc_run), .low_power(low_power), .irq(irq), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    bspd_seq_model u_bspd_seq_model (.sys_clk(sys_clk), .rst_b(rst_b), .run(run),
        .mode(mode), .step(step), .sense_en(sense_en), .osc_run(osc_run), .oe_a(ap_oe),
        .oe_b(bp_oe), .lvl_sel_a_hi(a_hi), .lvl_sel_a_lo(a_lo), .lvl_sel_b_hi(b_hi),
        .lvl_sel_b_lo(b_lo), .dir_a(d_a), .dir_b(d_b), .chop_osc_set(osc),
        .sense_ch_a(s_a), .sense_ch_b(s_b));

    // ============================================================
    // Verdict, comparison and bus tasks
    task automatic finish_test;
        if (n_fail == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bridge pins of one channel vs selects and direction
    task automatic chk_ch(input logic [3:0] got, input logic dir, input logic hi,
        input logic lo);
        chk({28'h0, got}, (hi | lo) ? {28'h0, 2'h3, dir, ~dir} : 32'h0);
    endtask

    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50)
            chk(32'h1, 32'h0);
    endtask

    // Let a chop period start and its bridge switch on
    task automatic wait_chop;
        @(posedge osc);
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic sleep_pulse;
        awake <= 1'b0;
        repeat (6) @(posedge sys_clk);
        awake <= 1'b1;
        repeat (5) @(posedge sys_clk);
    endtask

    // ============================================================
    // Watchdog well past the ~16k cycles the tests need
    initial
    begin
        #400000;
        n_fail++;
        finish_test();
    end

    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        awake <= 1'b1;
        bus(1'b0, `BSPD_REG_CTRL, 32'h0, 4'hF);
        chk(q, 32'h19);
        bus(1'b0, `BSPD_REG_MASK, 32'h0, 4'hF);
        chk(q, 32'h0);
        bus(1'b0, 4'h2, 32'h0, 4'hF);
        chk(q, 32'h0);
        bus(1'b1, `BSPD_REG_CTRL, 32'h55, 4'h0);
        bus(1'b0, `BSPD_REG_CTRL, 32'h0, 4'hF);
        chk(q, 32'h19);
        bus(1'b1, `BSPD_REG_MASK, 32'h6, 4'hF);
        bus(1'b0, `BSPD_REG_MASK, 32'h0, 4'hF);
        chk(q, 32'h6);
        // One supply monitor low: no bridge driven
        run <= 1'b1;
        wait_chop();
        chk({28'h0, oes}, 32'h0);
        {vcc_ok, motor_supply_ok} <= 2'h1;
        wait_chop();
        chk({28'h0, oes}, 32'h0);
        vcc_ok <= 1'b1;
        wait_chop();
        bus(1'b0, `BSPD_REG_STATUS, 32'h0, 4'hF);
        chk(q & 32'h8, 32'h8);
        // Every state of full, half and quarter stepping
        for (int m = 0; m < 3; m++)
        begin
            mode <= 2'(m);
            for (int i = 0; i < (4 << m); i++)
            begin
                @(posedge sys_clk);
                step <= 1'b1;
                @(posedge sys_clk);
                step <= 1'b0;
                repeat (5) @(posedge sys_clk);
                wait_chop();
                chk({30'h0, mag_a}, {30'h0, a_hi, a_lo});
                chk({30'h0, mag_b}, {30'h0, b_hi, b_lo});
                chk_ch({ap_oe, an_oe, ap_o & ap_oe, an_o & an_oe}, d_a, a_hi, a_lo);
                chk_ch({bp_oe, bn_oe, bp_o & bp_oe, bn_o & bn_oe}, d_b, b_hi, b_lo);
            end
        end
        // Sense reached: bridge drops before the next period
        mode <= 2'h0;
        sense_en <= 1'b1;
        repeat (5) @(posedge sys_clk);
        wait_chop();
        chk({28'h0, oes}, 32'hF);
        repeat (80) @(posedge sys_clk);
        chk({28'h0, oes}, 32'h0);
        sense_en <= 1'b0;
        // Thermal latch, interrupt masking and sleep release
        wait_chop();
        thermal_trip <= 1'b1;
        repeat (6) @(posedge sys_clk);
        thermal_trip <= 1'b0;
        chk({31'h0, irq}, 32'h0);
        chk({28'h0, oes}, 32'h0);
        bus(1'b0, `BSPD_REG_STATE, 32'h0, 4'hF);
        chk(q & 32'h1, 32'h1);
        wait_chop();
        chk({28'h0, oes}, 32'h0);
        bus(1'b1, `BSPD_REG_MASK, 32'h1, 4'hF);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, `BSPD_REG_STATUS, 32'h0, 4'hF);
        chk(q & 32'h1, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        awake <= 1'b0;
        repeat (6) @(posedge sys_clk);
        chk({26'h0, osc_run, low_power, oes}, 32'h10);
        awake <= 1'b1;
        repeat (5) @(posedge sys_clk);
        wait_chop();
        chk({28'h0, oes}, 32'hF);
        bus(1'b0, `BSPD_REG_STATE, 32'h0, 4'hF);
        chk(q & 32'h1, 32'h0);
        // Overcurrent of one channel leaves the other running
        for (int j = 0; j < 2; j++)
        begin
            oc_a <= (j == 0);
            oc_b <= (j == 1);
            repeat (6) @(posedge sys_clk);
            oc_a <= 1'b0;
            oc_b <= 1'b0;
            chk({28'h0, oes}, (j == 0) ? 32'h3 : 32'hC);
            bus(1'b0, `BSPD_REG_STATE, 32'h0, 4'hF);
            chk(q & 32'h6, (j == 0) ? 32'h2 : 32'h4);
            wait_chop();
            chk({28'h0, oes}, (j == 0) ? 32'h3 : 32'hC);
            sleep_pulse();
            wait_chop();
            chk({28'h0, oes}, 32'hF);
        end
        finish_test();
    end
endmodule
`default_nettype wire
